// File: logic/pcc_cfg.svh
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PCC_ADDR_PWM 8'hF7
`define PCC_ADDR_CLR 8'h9C
`define PCC_ADDR_MV_L0 8'hE9
`define PCC_ADDR_MV_H0 8'hEA
`define PCC_ADDR_MV_L1 8'hEB
`define PCC_ADDR_MV_H1 8'hEC
`define PCC_ADDR_MV_L2 8'hED
`define PCC_ADDR_MV_H2 8'hEE

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCC_BIT_BANK 7
`define PCC_BIT_WRAP_IE 6
`define PCC_BIT_WRAP_FLAG 5
`define PCC_BIT_POL 7

// ----------------------------------------
// Reset values and cycle masks
// ----------------------------------------
`define PCC_RST_BYTE 8'h00
`define PCC_RST_WORD 16'h0000
`define PCC_MASK_8 16'h00FF
`define PCC_MASK_9 16'h01FF
`define PCC_MASK_10 16'h03FF
`define PCC_MASK_11 16'h07FF
`define PCC_MASK_16 16'hFFFF

`endif

// File: logic/pcc_pkg.sv
`default_nettype none
package pcc_pkg;
	// Counter and match value word
	typedef logic [15:0] pcc_word_t;
	// Bank reached at the match value addresses
	typedef enum logic [0:0] {
		PCC_BANK_CMP = 1'b0,
		PCC_BANK_RLD = 1'b1
	} pcc_bank_t;
endpackage
`default_nettype wire

// File: logic/pcc_clr_if.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Control link to the comparator clear unit
// ----------------------------------------
interface pcc_clr_if;
	logic cmp_level; // Synchronised comparator result
	logic polarity; // Clearing edge select
	logic [2:0] enable; // Per-channel arm bits
	logic [2:0] cycle_start; // Per-channel cycle boundary
	logic [2:0] hold; // Per-channel forced-low state
	modport ctl (output cmp_level, output polarity, output enable, output cycle_start, input hold);
	modport clr (input cmp_level, input polarity, input enable, input cycle_start, output hold);
endinterface
`default_nettype wire

// File: logic/pcc_clr.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Comparator clear unit
// ----------------------------------------
module pcc_clr (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	pcc_clr_if.clr cif
);
	import pcc_pkg::*;

	logic cmp_prev_r; // Comparator level last cycle
	logic cmp_prev_nxt;
	logic [2:0] hold_r; // Channels held low
	logic [2:0] hold_nxt;
	logic fire; // Selected comparator edge

	// Edge pick and hold update
	always_comb begin
		cmp_prev_nxt = cif.cmp_level;
		// High-going edge or low-going edge
		fire = cif.polarity ? (cif.cmp_level & ~cmp_prev_r) : (~cif.cmp_level & cmp_prev_r);
		// New cycle releases, armed edge sets
		hold_nxt = (hold_r & ~cif.cycle_start) | (cif.enable & {3{fire}});
	end

	// State registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmp_prev_r <= 1'b0;
			hold_r <= 3'h0;
		end else if (ce) begin
			cmp_prev_r <= cmp_prev_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign cif.hold = hold_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Armed ch0 rising edge
	sequence s_rise_ch0;
		ce && cif.enable[0] && cif.polarity && cif.cmp_level && !cmp_prev_r;
	endsequence
	// Armed ch2 falling edge
	sequence s_fall_ch2;
		ce && cif.enable[2] && !cif.polarity && !cif.cmp_level && cmp_prev_r;
	endsequence

	property p_clear_fires;
		@(posedge clk) disable iff (!rstn)
		s_rise_ch0 |=> hold_r[0];
	endproperty
	a_clear_fires: assert property (p_clear_fires) else $error("armed edge did not hold ch0");

	property p_clear_falls;
		@(posedge clk) disable iff (!rstn)
		s_fall_ch2 |=> hold_r[2];
	endproperty
	a_clear_falls: assert property (p_clear_falls) else $error("armed falling edge did not hold ch2");

	property p_unarmed;
		@(posedge clk) disable iff (!rstn)
		(ce && !cif.enable[1] && (!hold_r[1] || cif.cycle_start[1])) |=> !hold_r[1];
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("unarmed ch1 was held");

	property p_hold_stays;
		@(posedge clk) disable iff (!rstn)
		(ce && hold_r[2] && !cif.cycle_start[2]) |=> hold_r[2];
	endproperty
	a_hold_stays: assert property (p_hold_stays) else $error("ch2 hold released early");
endmodule
`default_nettype wire

// File: logic/pcc_top.sv
// Behaviour
// - Bank bit steers match-address reads and writes
// - Reload used only for 9-11 bit PWM
// - Flag with enable requests the interrupt
// - Flag sets on selected counter bit overflow
// - Flag set by hardware or software only
// - Length codes give 8 to 11 bits
// - Cycle length ignored by wide channels
// - Polarity bit picks clearing comparator edge
// - Per-channel enables arm comparator clear
// - Wide bit picks shared length or 16-bit
`timescale 1ns/1ns
`default_nettype none
`include "pcc_cfg.svh"
module pcc_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire pcc_pkg::pcc_word_t array_main_counter,
	input wire logic counter_tick,
	input wire logic [2:0] pwm_mode,
	input wire logic [2:0] wide_mode_select,
	input wire logic cmp_result,
	output logic channel_out_0,
	output logic channel_out_1,
	output logic channel_out_2,
	output logic cycle_wrap_irq
);
	import pcc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Count mask for the channel's cycle length
	function automatic pcc_word_t len_mask(input logic wide, input logic [2:0] sel);
		pcc_word_t m;
		m = `PCC_MASK_8;
		if (wide) begin
			m = `PCC_MASK_16;
		end else begin
			case (sel)
				3'h0: m = `PCC_MASK_8;
				3'h1: m = `PCC_MASK_9;
				3'h2: m = `PCC_MASK_10;
				3'h3: m = `PCC_MASK_11;
				default: m = `PCC_MASK_8; // Reserved codes
			endcase
		end
		return m;
	endfunction

	// Match address decode: hit, channel, high byte
	function automatic logic [3:0] mv_dec(input logic [7:0] a);
		logic [3:0] d;
		d = 4'h0;
		case (a)
			`PCC_ADDR_MV_L0: d = 4'h8;
			`PCC_ADDR_MV_H0: d = 4'h9;
			`PCC_ADDR_MV_L1: d = 4'hA;
			`PCC_ADDR_MV_H1: d = 4'hB;
			`PCC_ADDR_MV_L2: d = 4'hC;
			`PCC_ADDR_MV_H2: d = 4'hD;
			default: d = 4'h0;
		endcase
		return d;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	pcc_bank_t bank_r, bank_nxt; // Match address bank
	logic wrap_ie_r, wrap_ie_nxt; // Cycle wrap interrupt enable
	logic flag_r, flag_nxt; // Cycle wrap flag
	logic [2:0] cycle_length_select_r, cycle_length_select_nxt; // Cycle length select
	logic pol_r, pol_nxt; // Comparator clear polarity
	logic [2:0] cpe_r, cpe_nxt; // Comparator clear enables
	pcc_word_t match_r [3]; // Compare values
	pcc_word_t match_nxt [3];
	pcc_word_t reload_r [3]; // Auto-reload values
	pcc_word_t reload_nxt [3];
	logic [7:0] rdata_r, rdata_nxt; // Read data
	logic irq_r, irq_nxt; // Interrupt request
	logic [2:0] out_r, out_nxt; // Channel outputs
	logic cmp_s1_r, cmp_s2_r; // Comparator synchroniser
	logic [3:0] dec; // Match address decode
	logic wr_pwm, wr_clr; // Register write strobes
	logic wrap_evt; // Shared cycle overflow
	logic [2:0] cyc_start; // Per-channel cycle boundary
	pcc_word_t ch_mask [3]; // Per-channel count mask

	pcc_clr_if cif ();

	// ----------------------------------------
	// Decode and cycle events
	// ----------------------------------------
	always_comb begin
		dec = mv_dec(sfr_addr);
		wr_pwm = sfr_wr && (sfr_addr == `PCC_ADDR_PWM);
		wr_clr = sfr_wr && (sfr_addr == `PCC_ADDR_CLR);
		// Selected counter bit overflows on this tick
		wrap_evt = counter_tick && ((array_main_counter & len_mask(1'b0, cycle_length_select_r)) == len_mask(1'b0, cycle_length_select_r));
		for (int i = 0; i < 3; i++) begin
			ch_mask[i] = len_mask(wide_mode_select[i], cycle_length_select_r);
			cyc_start[i] = counter_tick && ((array_main_counter & ch_mask[i]) == ch_mask[i]);
		end
	end

	// ----------------------------------------
	// Configuration registers, next values
	// ----------------------------------------
	always_comb begin
		bank_nxt = bank_r;
		wrap_ie_nxt = wrap_ie_r;
		cycle_length_select_nxt = cycle_length_select_r;
		pol_nxt = pol_r;
		cpe_nxt = cpe_r;
		flag_nxt = flag_r;
		// Reserved bits are not stored
		if (wr_pwm) begin
			bank_nxt = pcc_bank_t'(sfr_wdata[`PCC_BIT_BANK]);
			wrap_ie_nxt = sfr_wdata[`PCC_BIT_WRAP_IE];
			cycle_length_select_nxt = sfr_wdata[2:0];
			flag_nxt = sfr_wdata[`PCC_BIT_WRAP_FLAG];
		end
		if (wr_clr) begin
			pol_nxt = sfr_wdata[`PCC_BIT_POL];
			cpe_nxt = sfr_wdata[2:0];
		end
		// Hardware only sets, and wins over a write of 0
		if (wrap_evt) begin
			flag_nxt = 1'b1;
		end
		irq_nxt = flag_r && wrap_ie_r;
	end

	// ----------------------------------------
	// Match and reload banks, next values
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			match_nxt[i] = match_r[i];
			reload_nxt[i] = reload_r[i];
			// Reload only for PWM with 9 to 11 bit cycle
			if (cyc_start[i] && pwm_mode[i] && !wide_mode_select[i] && cycle_length_select_r != 3'h0 && !cycle_length_select_r[2]) begin
				match_nxt[i] = reload_r[i];
			end
		end
		// Software access goes to the selected bank
		if (sfr_wr && dec[3]) begin
			if (bank_r == PCC_BANK_RLD) begin
				if (dec[0]) reload_nxt[dec[2:1]][15:8] = sfr_wdata;
				else reload_nxt[dec[2:1]][7:0] = sfr_wdata;
			end else begin
				if (dec[0]) match_nxt[dec[2:1]][15:8] = sfr_wdata;
				else match_nxt[dec[2:1]][7:0] = sfr_wdata;
			end
		end
	end

	// ----------------------------------------
	// Read data and outputs, next values
	// ----------------------------------------
	always_comb begin
		rdata_nxt = rdata_r;
		if (sfr_rd) begin
			rdata_nxt = `PCC_RST_BYTE; // Unmapped reads zero
			if (sfr_addr == `PCC_ADDR_PWM) begin
				rdata_nxt = {bank_r, wrap_ie_r, flag_r, 2'b00, cycle_length_select_r};
			end else if (sfr_addr == `PCC_ADDR_CLR) begin
				rdata_nxt = {pol_r, 4'h0, cpe_r};
			end else if (dec[3]) begin
				if (bank_r == PCC_BANK_RLD) begin
					rdata_nxt = dec[0] ? reload_r[dec[2:1]][15:8] : reload_r[dec[2:1]][7:0];
				end else begin
					rdata_nxt = dec[0] ? match_r[dec[2:1]][15:8] : match_r[dec[2:1]][7:0];
				end
			end
		end
		// High while count below match, forced low by clear
		for (int i = 0; i < 3; i++) begin
			out_nxt[i] = pwm_mode[i] && !cif.hold[i] &&
				((array_main_counter & ch_mask[i]) < (match_r[i] & ch_mask[i]));
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bank_r <= PCC_BANK_CMP;
			wrap_ie_r <= 1'b0;
			flag_r <= 1'b0;
			cycle_length_select_r <= 3'h0;
			pol_r <= 1'b0;
			cpe_r <= 3'h0;
			rdata_r <= `PCC_RST_BYTE;
			irq_r <= 1'b0;
			out_r <= 3'h0;
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				match_r[i] <= `PCC_RST_WORD;
				reload_r[i] <= `PCC_RST_WORD;
			end
		end else if (ce) begin
			bank_r <= bank_nxt;
			wrap_ie_r <= wrap_ie_nxt;
			flag_r <= flag_nxt;
			cycle_length_select_r <= cycle_length_select_nxt;
			pol_r <= pol_nxt;
			cpe_r <= cpe_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			out_r <= out_nxt;
			cmp_s1_r <= cmp_result;
			cmp_s2_r <= cmp_s1_r;
			for (int i = 0; i < 3; i++) begin
				match_r[i] <= match_nxt[i];
				reload_r[i] <= reload_nxt[i];
			end
		end
	end

	// ----------------------------------------
	// Comparator clear unit
	// ----------------------------------------
	assign cif.cmp_level = cmp_s2_r;
	assign cif.polarity = pol_r;
	assign cif.enable = cpe_r;
	assign cif.cycle_start = cyc_start;

	pcc_clr u_clr (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.cif(cif)
	);

	assign sfr_rdata = rdata_r;
	assign cycle_wrap_irq = irq_r;
	assign channel_out_0 = out_r[0];
	assign channel_out_1 = out_r[1];
	assign channel_out_2 = out_r[2];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_bank_write;
		@(posedge clk) disable iff (!rstn)
		(ce && sfr_wr && sfr_addr == `PCC_ADDR_MV_L0 && bank_r == PCC_BANK_RLD) |=>
			(reload_r[0][7:0] == $past(sfr_wdata) && match_r[0] == $past(match_nxt[0]));
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("reload bank write misrouted");

	property p_reload;
		@(posedge clk) disable iff (!rstn)
		(ce && cyc_start[0] && pwm_mode[0] && !wide_mode_select[0] && (cycle_length_select_r inside {3'h1, 3'h2, 3'h3}) &&
			!(sfr_wr && dec[3]))
			|=> match_r[0] == $past(reload_r[0]);
	endproperty
	a_reload: assert property (p_reload) else $error("reload not applied");

	property p_no_reload_wide;
		@(posedge clk) disable iff (!rstn)
		(ce && wide_mode_select[1] && !(sfr_wr && dec[3])) |=> $stable(match_r[1]);
	endproperty
	a_no_reload_wide: assert property (p_no_reload_wide) else $error("wide channel reloaded");

	property p_irq;
		@(posedge clk) disable iff (!rstn)
		ce |=> (irq_r == ($past(flag_r) && $past(wrap_ie_r)));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt request mismatch");

	property p_wrap8;
		@(posedge clk) disable iff (!rstn)
		(ce && counter_tick && cycle_length_select_r == 3'h0 && array_main_counter[7:0] == 8'hFF) |=> flag_r;
	endproperty
	a_wrap8: assert property (p_wrap8) else $error("8-bit wrap missed");

	property p_set_wins;
		@(posedge clk) disable iff (!rstn)
		(ce && wrap_evt && wr_pwm && !sfr_wdata[`PCC_BIT_WRAP_FLAG]) |=> flag_r;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat hardware set");

	property p_sticky;
		@(posedge clk) disable iff (!rstn)
		(flag_r && !(ce && wr_pwm)) |=> flag_r;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

	property p_held_low;
		@(posedge clk) disable iff (!rstn)
		(ce && cif.hold[0]) |=> !channel_out_0;
	endproperty
	a_held_low: assert property (p_held_low) else $error("cleared channel not low");
endmodule
`default_nettype wire

// File: tb/pcc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Processor side of the register bus
// ----------------------------------------
module pcc_cpu_model (
	input wire logic clk,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	output logic sfr_wr,
	output logic sfr_rd,
	input wire logic [7:0] sfr_rdata
);
	// Idle bus at time zero
	initial begin
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	end
	// One write strobe, released lines show inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == 8'hF7) v = v & 8'hE7;
		if (a == 8'h9C) v = v & 8'h87;
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~v;
	endtask
	// One read strobe, data taken once registered
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		@(posedge clk);
		#1;
		d = sfr_rdata;
	endtask
endmodule
`default_nettype wire

// File: tb/pwm_cycle_and_comparator_clear_test.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_cycle_and_comparator_clear_test;
	import pcc_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1; // Clock enable, dropped only in t_ce
	logic tick = 1'b0;
	logic cmp = 1'b0; // Comparator result
	logic [2:0] mode = 3'h0;
	logic [2:0] wide = 3'h0;
	pcc_word_t cnt = 16'h0000;
	logic [7:0] a;
	logic [7:0] wd;
	logic [7:0] rdat;
	logic wr;
	logic rd;
	logic o0;
	logic o1;
	logic o2;
	logic irq;
	int miscompares = 0;
	int cmp_count = 0;
	int cyc = 0;
	// 100 MHz clock
	always #5 clk = ~clk;
	pcc_cpu_model cpu (.clk(clk), .sfr_addr(a), .sfr_wdata(wd), .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdat));
	pcc_top dut (.clk(clk), .rstn(rstn), .ce(ce), .sfr_addr(a), .sfr_wdata(wd), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_rdata(rdat), .array_main_counter(cnt), .counter_tick(tick), .pwm_mode(mode),
		.wide_mode_select(wide), .cmp_result(cmp), .channel_out_0(o0), .channel_out_1(o1),
		.channel_out_2(o2), .cycle_wrap_irq(irq));
	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic print_verdict;
		$display("compares=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			print_verdict;
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
		logic [7:0] d;
		cpu.rd(ad, d);
		chk(d, exp);
	endtask
	// One counter step at a given value
	task automatic tk(input pcc_word_t v);
		@(posedge clk);
		#1;
		cnt = v;
		tick = 1'b1;
		@(posedge clk);
		#1;
		tick = 1'b0;
	endtask
	// Let synchroniser and output stages land
	task automatic settle;
		repeat (8) @(posedge clk);
		#1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		rchk(8'hF7, 8'h00);
		rchk(8'h9C, 8'h00);
		rchk(8'h80, 8'h00);
		cpu.wr(8'hF7, 8'hFF);
		rchk(8'hF7, 8'hE7);
		chk({7'h00, irq}, 8'h01);
		cpu.wr(8'hF7, 8'h00);
		rchk(8'hF7, 8'h00);
		chk({7'h00, irq}, 8'h00);
		cpu.wr(8'h9C, 8'hFF);
		rchk(8'h9C, 8'h87);
		cpu.wr(8'h9C, 8'h00);
	endtask
	task automatic t_bank;
		cpu.wr(8'hE9, 8'h12);
		cpu.wr(8'hF7, 8'h80);
		cpu.wr(8'hE9, 8'h34);
		rchk(8'hE9, 8'h34);
		cpu.wr(8'hF7, 8'h00);
		rchk(8'hE9, 8'h12);
	endtask
	// Each length code, reserved one as 8 bits
	task automatic t_wrap;
		pcc_word_t m;
		for (int c = 0; c < 5; c++) begin
			m = (16'h0100 << ((c < 4) ? c : 0)) - 16'h0001;
			cpu.wr(8'hF7, 8'h40 | 8'(c));
			tk(m >> 1);
			rchk(8'hF7, 8'h40 | 8'(c));
			chk({7'h00, irq}, 8'h00);
			tk(m);
			rchk(8'hF7, 8'h60 | 8'(c));
			chk({7'h00, irq}, 8'h01);
			cpu.wr(8'hF7, 8'h20 | 8'(c));
			settle;
			chk({7'h00, irq}, 8'h00);
			cpu.wr(8'hF7, 8'(c));
		end
	endtask
	// Software clear in the wrap cycle
	task automatic t_race;
		cpu.wr(8'hF7, 8'h20);
		fork
			cpu.wr(8'hF7, 8'h00);
			tk(16'h00FF);
		join
		rchk(8'hF7, 8'h20);
		cpu.wr(8'hF7, 8'h00);
		rchk(8'hF7, 8'h00);
	endtask
	// Frozen clock enable drops a write
	task automatic t_ce;
		@(posedge clk);
		#1;
		ce = 1'b0;
		cpu.wr(8'hF7, 8'h20);
		ce = 1'b1;
		rchk(8'hF7, 8'h00);
	endtask
	task automatic t_pwm;
		cpu.wr(8'hE9, 8'h80);
		cpu.wr(8'hEA, 8'h01);
		cpu.wr(8'hEB, 8'h80);
		cpu.wr(8'hEC, 8'h01);
		cpu.wr(8'hED, 8'h80);
		cpu.wr(8'hEE, 8'h01);
		mode = 3'h7;
		wide = 3'h2;
		cnt = 16'h0090;
		settle;
		chk({5'h00, o2, o1, o0}, 8'h02);
		cpu.wr(8'hF7, 8'h80);
		cpu.wr(8'hED, 8'h40);
		cpu.wr(8'hEE, 8'h00);
		cpu.wr(8'hF7, 8'h00);
		tk(16'h00FF);
		rchk(8'hED, 8'h80);
		cpu.wr(8'hF7, 8'h01);
		tk(16'h01FF);
		rchk(8'hED, 8'h40);
		cnt = 16'h0050;
		settle;
		chk({5'h00, o2, o1, o0}, 8'h02);
	endtask
	task automatic t_clr;
		cpu.wr(8'hF7, 8'h00);
		cpu.wr(8'hE9, 8'h80);
		cpu.wr(8'hEA, 8'h00);
		cpu.wr(8'hED, 8'h80);
		cnt = 16'h0010;
		settle;
		chk({5'h00, o2, o1, o0}, 8'h07);
		cpu.wr(8'h9C, 8'h81);
		cmp = 1'b1;
		settle;
		chk({5'h00, o2, o1, o0}, 8'h06);
		cmp = 1'b0;
		settle;
		chk({5'h00, o2, o1, o0}, 8'h06);
		tk(16'h00FF);
		cnt = 16'h0010;
		settle;
		chk({5'h00, o2, o1, o0}, 8'h07);
		cpu.wr(8'h9C, 8'h04);
		cmp = 1'b1;
		settle;
		chk({5'h00, o2, o1, o0}, 8'h07);
		cmp = 1'b0;
		settle;
		chk({5'h00, o2, o1, o0}, 8'h03);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rstn = 1'b1;
		t_regs;
		t_bank;
		t_wrap;
		t_race;
		t_ce;
		t_pwm;
		t_clr;
		print_verdict;
	end
endmodule
`default_nettype wire
